// ---- design/stp_consts.svh ----
// Constants of the stepper serial configuration port
`ifndef STP_CONSTS_SVH
`define STP_CONSTS_SVH

`define STP_WORD_W        20
`define STP_CLK_NS        5
`define STP_FILT_NS       20
`define STP_FILT_CYC      ((`STP_FILT_NS + `STP_CLK_NS - 1) / `STP_CLK_NS)
`define STP_RST_WORD      20'h00000

`define STP_ADDR_MSB      19
`define STP_ADDR_LSB      17
`define STP_ADDR_COIL     2'h0
`define STP_ADDR_CHOP     3'h4
`define STP_ADDR_LACUR    3'h5
`define STP_ADDR_LDET     3'h6
`define STP_ADDR_DCONF    3'h7

`define STP_MASK_COIL_SPI  20'h3ffff
`define STP_MASK_COIL_STEP 20'h0030f
`define STP_MASK_CHOP      20'h1ffff
`define STP_MASK_LACUR     20'h0ef6f
`define STP_MASK_LDET      20'h17f1f
`define STP_MASK_DCONF     20'h1f7ff
`define STP_MASK_DCONF_EXT 20'h0000f

`define STP_A_POL         17
`define STP_A_MAG         16:9
`define STP_B_POL         8
`define STP_B_MAG         7:0
`define STP_INTERP_EN     9
`define STP_DOUBLE_EDGE   8
`define STP_USTEP_RES     3:0
`define STP_STEP_IF_OFF   7
`define STP_SENSE_RANGE   6
`define STP_READ_SEL      5:4
`define STP_ZERO_MAG      8'h00
`define STP_ZERO_RES      4'h0

`define STP_READ_POS      2'h0
`define STP_READ_LOAD     2'h1
`define STP_READ_LDCUR    2'h2
`define STP_READ_DIAG     2'h3
`define STP_PAD_ZERO      2'h0
`define STP_PAD_DIAG      2'h3
`define STP_LOAD_HI       9:5

`endif

// ---- design/stp_in_filter.sv ----
// Three-stage synchroniser with a short-pulse filter for one pin
`timescale 1ns/1ps
`include "stp_consts.svh"
module stp_in_filter #(
	parameter int   FILT_CYC = `STP_FILT_CYC,
	parameter logic INIT     = 1'b1
) (
	input  wire logic clock,
	input  wire logic reset_n,
	input  wire logic ce,
	input  wire logic pin,
	output logic      level
);
	localparam int CW = $clog2(FILT_CYC + 1);
	localparam logic [CW-1:0] LAST = CW'(FILT_CYC - 1);

	logic          s1;
	logic          s2;
	logic          s3;
	logic [CW-1:0] cnt;

	always_ff @(posedge clock or negedge reset_n)
		if (!reset_n)
		begin
			s1 <= INIT;
			s2 <= INIT;
			s3 <= INIT;
		end
		else if (ce)
		begin
			s1 <= pin;
			s2 <= s1;
			s3 <= s2;
		end

	// A new level must hold for the whole filter time before it is taken
	always_ff @(posedge clock or negedge reset_n)
		if (!reset_n)
		begin
			cnt   <= '0;
			level <= INIT;
		end
		else if (ce)
		begin
			if (s2 == s3 && s3 != level)
			begin
				if (cnt == LAST)
				begin
					level <= s3;
					cnt   <= '0;
				end
				else
					cnt <= cnt + CW'(1);
			end
			else
				cnt <= '0;
		end

	a_glitch_reject: assert property (@(posedge clock) disable iff (!reset_n)
		(level != $past(level)) |-> ($past(cnt) == LAST && $past(s3) == level))
		else $error("filtered level changed before the filter time");
endmodule

// ---- design/stp_pkg.sv ----
// Types shared by the stepper serial configuration port
package stp_pkg;
	typedef enum {TGT_COIL, TGT_CHOP, TGT_LACUR, TGT_LDET, TGT_DCONF} stp_target_e;
endpackage

// ---- design/stp_resp_format.sv ----
// Status word shifted out on the serial output, chosen by readback_select
`timescale 1ns/1ps
`include "stp_consts.svh"
module stp_resp_format (
	input  wire logic [1:0] readback_select,
	input  wire logic [9:0] microstep_pos,
	input  wire logic [9:0] load_value,
	input  wire logic [4:0] current_scale_actual,
	input  wire logic [8:0] protect_flags,
	input  wire logic       driver_disable,
	input  wire logic [7:0] diag_flags,
	output logic [19:0]     word
);
	always_comb
	begin
		unique case (readback_select)
			`STP_READ_POS:  word = {microstep_pos, `STP_PAD_ZERO, diag_flags};
			`STP_READ_LOAD: word = {load_value, `STP_PAD_ZERO, diag_flags};
			`STP_READ_LDCUR:
				word = {load_value[`STP_LOAD_HI], current_scale_actual,
					`STP_PAD_ZERO, diag_flags};
			`STP_READ_DIAG:
				word = {protect_flags[8], driver_disable, protect_flags[7:0],
					`STP_PAD_DIAG, diag_flags};
		endcase
	end
endmodule

// ---- design/stp_spi_config_writer.sv ----
// Serial configuration port: shift register, command decode, config registers
`timescale 1ns/1ps
`include "stp_consts.svh"
module stp_spi_config_writer #(
	parameter logic ENHANCED = 1'b1
) (
	input  wire logic        clock,
	input  wire logic        reset_n,
	input  wire logic        ce,
	input  wire logic        sck,
	input  wire logic        sdi,
	input  wire logic        select_low,
	input  wire logic        driver_disable_in,
	input  wire logic [9:0]  microstep_pos,
	input  wire logic [9:0]  load_value,
	input  wire logic [4:0]  current_scale_actual,
	input  wire logic [8:0]  protect_flags,
	input  wire logic [7:0]  diag_flags,
	output logic             sdo,
	output logic             sdo_en,
	output logic             driver_disable,
	output logic [19:0]      coil_drive_word,
	output logic [19:0]      chopper_config,
	output logic [19:0]      load_adaptive_current_config,
	output logic [19:0]      load_detect_config,
	output logic [19:0]      driver_config,
	output logic             step_interface_off,
	output logic [1:0]       readback_select,
	output logic             sense_voltage_range,
	output logic             coil_a_polarity,
	output logic [7:0]       coil_a_magnitude,
	output logic             coil_b_polarity,
	output logic [7:0]       coil_b_magnitude,
	output logic             step_interpolation_en,
	output logic             double_edge_step,
	output logic [3:0]       microstep_resolution
);
	localparam logic [19:0] DCONF_MASK = ENHANCED ? `STP_MASK_DCONF
		: (`STP_MASK_DCONF & ~`STP_MASK_DCONF_EXT);

	logic        sck_lvl;
	logic        sdi_lvl;
	logic        sel_n_lvl;
	logic        sck_prev;
	logic        sel_prev;
	logic        sck_rise;
	logic        sck_fall;
	logic        sel_fall;
	logic        sel_rise;
	logic        active;
	logic        load_now;
	logic [19:0] shreg;
	logic [19:0] resp_word;

	////////////////////////////////////////////////////////////////////////////
	// Target register from the address bits of a command
	function automatic stp_pkg::stp_target_e target_of(input logic [19:0] w);
		logic [2:0] a;
		a = w[`STP_ADDR_MSB:`STP_ADDR_LSB];
		target_of = stp_pkg::TGT_COIL;
		case (a)
			`STP_ADDR_CHOP:  target_of = stp_pkg::TGT_CHOP;
			`STP_ADDR_LACUR: target_of = stp_pkg::TGT_LACUR;
			`STP_ADDR_LDET:  target_of = stp_pkg::TGT_LDET;
			`STP_ADDR_DCONF: target_of = stp_pkg::TGT_DCONF;
			default:         target_of = stp_pkg::TGT_COIL;
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Pin conditioning; the link clock is sampled, not used as a clock
	stp_in_filter #(.FILT_CYC(`STP_FILT_CYC), .INIT(1'b1)) u_sck (
		.clock   (clock),
		.reset_n (reset_n),
		.ce      (ce),
		.pin     (sck),
		.level   (sck_lvl)
	);

	stp_in_filter #(.FILT_CYC(`STP_FILT_CYC), .INIT(1'b0)) u_sdi (
		.clock   (clock),
		.reset_n (reset_n),
		.ce      (ce),
		.pin     (sdi),
		.level   (sdi_lvl)
	);

	stp_in_filter #(.FILT_CYC(`STP_FILT_CYC), .INIT(1'b1)) u_sel (
		.clock   (clock),
		.reset_n (reset_n),
		.ce      (ce),
		.pin     (select_low),
		.level   (sel_n_lvl)
	);

	// Disable pin gets the same filter so a spike cannot stop the bridge
	stp_in_filter #(.FILT_CYC(`STP_FILT_CYC), .INIT(1'b1)) u_dis (
		.clock   (clock),
		.reset_n (reset_n),
		.ce      (ce),
		.pin     (driver_disable_in),
		.level   (driver_disable)
	);

	stp_resp_format u_resp (
		.readback_select      (readback_select),
		.microstep_pos        (microstep_pos),
		.load_value           (load_value),
		.current_scale_actual (current_scale_actual),
		.protect_flags        (protect_flags),
		.driver_disable       (driver_disable),
		.diag_flags           (diag_flags),
		.word                 (resp_word)
	);

	////////////////////////////////////////////////////////////////////////////
	// Edge detection on the filtered levels
	always_ff @(posedge clock or negedge reset_n)
		if (!reset_n)
		begin
			sck_prev <= 1'b1;
			sel_prev <= 1'b1;
		end
		else if (ce)
		begin
			sck_prev <= sck_lvl;
			sel_prev <= sel_n_lvl;
		end

	assign active   = ~sel_n_lvl;
	assign sck_rise = sck_lvl & ~sck_prev;
	assign sck_fall = ~sck_lvl & sck_prev;
	assign sel_fall = sel_prev & ~sel_n_lvl;
	assign sel_rise = ~sel_prev & sel_n_lvl;
	assign load_now = ce & sel_rise;

	////////////////////////////////////////////////////////////////////////////
	// Twenty-stage shift register; status is parked in it when select falls
	always_ff @(posedge clock or negedge reset_n)
		if (!reset_n)
			shreg <= `STP_RST_WORD;
		else if (ce)
		begin
			if (sel_fall)
				shreg <= resp_word;
			else if (active && sck_rise)
				shreg <= {shreg[18:0], sdi_lvl};
		end

	// Output bit changes only at select fall or after a falling clock, MSB leaves first
	always_ff @(posedge clock or negedge reset_n)
		if (!reset_n)
		begin
			sdo    <= 1'b0;
			sdo_en <= 1'b0;
		end
		else if (ce)
		begin
			sdo_en <= active;
			if (sel_fall)
				sdo <= resp_word[19];
			else if (active && sck_fall)
				sdo <= shreg[19];
		end

	////////////////////////////////////////////////////////////////////////////
	// Command load on select rise; the shift register holds the last 20 bits
	// Only written fields are kept, so fixed bits never reach the outputs
	always_ff @(posedge clock or negedge reset_n)
		if (!reset_n)
			chopper_config <= `STP_RST_WORD;
		else if (load_now && target_of(shreg) == stp_pkg::TGT_CHOP)
			chopper_config <= shreg & `STP_MASK_CHOP;

	always_ff @(posedge clock or negedge reset_n)
		if (!reset_n)
			load_adaptive_current_config <= `STP_RST_WORD;
		else if (load_now && target_of(shreg) == stp_pkg::TGT_LACUR)
			load_adaptive_current_config <= shreg & `STP_MASK_LACUR;

	always_ff @(posedge clock or negedge reset_n)
		if (!reset_n)
			load_detect_config <= `STP_RST_WORD;
		else if (load_now && target_of(shreg) == stp_pkg::TGT_LDET)
			load_detect_config <= shreg & `STP_MASK_LDET;

	// Base variant drops the protection option bits entirely
	always_ff @(posedge clock or negedge reset_n)
		if (!reset_n)
		begin
			driver_config       <= `STP_RST_WORD;
			step_interface_off  <= 1'b0;
			readback_select     <= `STP_READ_POS;
			sense_voltage_range <= 1'b0;
		end
		else if (load_now && target_of(shreg) == stp_pkg::TGT_DCONF)
		begin
			driver_config       <= shreg & DCONF_MASK;
			step_interface_off  <= shreg[`STP_STEP_IF_OFF];
			readback_select     <= shreg[`STP_READ_SEL];
			sense_voltage_range <= shreg[`STP_SENSE_RANGE];
		end

	// Coil word meaning follows the interface mode at the time of the write
	always_ff @(posedge clock or negedge reset_n)
		if (!reset_n)
		begin
			coil_drive_word       <= `STP_RST_WORD;
			coil_a_polarity       <= 1'b0;
			coil_a_magnitude      <= `STP_ZERO_MAG;
			coil_b_polarity       <= 1'b0;
			coil_b_magnitude      <= `STP_ZERO_MAG;
			step_interpolation_en <= 1'b0;
			double_edge_step      <= 1'b0;
			microstep_resolution  <= `STP_ZERO_RES;
		end
		else if (load_now && target_of(shreg) == stp_pkg::TGT_COIL)
		begin
			if (step_interface_off)
			begin
				coil_drive_word       <= shreg & `STP_MASK_COIL_SPI;
				coil_a_polarity       <= shreg[`STP_A_POL];
				coil_a_magnitude      <= shreg[`STP_A_MAG];
				coil_b_polarity       <= shreg[`STP_B_POL];
				coil_b_magnitude      <= shreg[`STP_B_MAG];
				step_interpolation_en <= 1'b0;
				double_edge_step      <= 1'b0;
				microstep_resolution  <= `STP_ZERO_RES;
			end
			else
			begin
				coil_drive_word       <= shreg & `STP_MASK_COIL_STEP;
				coil_a_polarity       <= 1'b0;
				coil_a_magnitude      <= `STP_ZERO_MAG;
				coil_b_polarity       <= 1'b0;
				coil_b_magnitude      <= `STP_ZERO_MAG;
				step_interpolation_en <= shreg[`STP_INTERP_EN];
				double_edge_step      <= shreg[`STP_DOUBLE_EDGE];
				microstep_resolution  <= shreg[`STP_USTEP_RES];
			end
		end

	////////////////////////////////////////////////////////////////////////////
	// Checks
	a_shift_on_rise: assert property (@(posedge clock) disable iff (!reset_n)
		(ce && active && sck_rise && !sel_fall)
		|=> shreg == {$past(shreg[18:0]), $past(sdi_lvl)})
		else $error("shift register did not take input on rising clock");

	a_sdo_on_fall: assert property (@(posedge clock) disable iff (!reset_n)
		(ce && active && sck_fall && !sel_fall) |=> sdo == $past(shreg[19]))
		else $error("output bit not updated after falling clock");

	a_sdo_steady: assert property (@(posedge clock) disable iff (!reset_n)
		(ce && !sck_fall && !sel_fall) |=> $stable(sdo))
		else $error("output bit moved without a falling clock");

	a_idle_no_shift: assert property (@(posedge clock) disable iff (!reset_n)
		(sel_n_lvl ##1 sel_n_lvl) |=> $stable(shreg))
		else $error("shift register moved while not selected");

	a_load_chopper: assert property (@(posedge clock) disable iff (!reset_n)
		(load_now && shreg[`STP_ADDR_MSB:`STP_ADDR_LSB] == `STP_ADDR_CHOP)
		|=> chopper_config == ($past(shreg) & `STP_MASK_CHOP) && $stable(coil_drive_word))
		else $error("chopper command not loaded from last 20 bits");

	a_no_load_busy: assert property (@(posedge clock) disable iff (!reset_n)
		(!load_now) |=> $stable(driver_config) && $stable(load_detect_config))
		else $error("configuration changed without select rise");

	a_base_variant: assert property (@(posedge clock) disable iff (!reset_n)
		ENHANCED || (driver_config & `STP_MASK_DCONF_EXT) == `STP_RST_WORD)
		else $error("option bits stored on base variant");

	a_step_mode_coil: assert property (@(posedge clock) disable iff (!reset_n)
		(load_now && target_of(shreg) == stp_pkg::TGT_COIL && !step_interface_off)
		|=> coil_a_magnitude == `STP_ZERO_MAG
			&& microstep_resolution == $past(shreg[`STP_USTEP_RES]))
		else $error("coil word decoded in wrong format");

	a_load_lacur: assert property (@(posedge clock) disable iff (!reset_n)
		(load_now && shreg[`STP_ADDR_MSB:`STP_ADDR_LSB] == `STP_ADDR_LACUR)
		|=> load_adaptive_current_config == ($past(shreg) & `STP_MASK_LACUR))
		else $error("load-adaptive command not loaded");

	a_load_detect: assert property (@(posedge clock) disable iff (!reset_n)
		(load_now && shreg[`STP_ADDR_MSB:`STP_ADDR_LSB] == `STP_ADDR_LDET)
		|=> load_detect_config == ($past(shreg) & `STP_MASK_LDET))
		else $error("load detection command not loaded");

	a_load_dconf: assert property (@(posedge clock) disable iff (!reset_n)
		(load_now && shreg[`STP_ADDR_MSB:`STP_ADDR_LSB] == `STP_ADDR_DCONF)
		|=> driver_config == ($past(shreg) & DCONF_MASK)
			&& readback_select == $past(shreg[`STP_READ_SEL]))
		else $error("driver configuration command not loaded");

	a_mode_bits: assert property (@(posedge clock) disable iff (!reset_n)
		(load_now && target_of(shreg) == stp_pkg::TGT_DCONF)
		|=> step_interface_off == $past(shreg[`STP_STEP_IF_OFF])
			&& sense_voltage_range == $past(shreg[`STP_SENSE_RANGE]))
		else $error("mode bits not taken from driver configuration");

	a_spi_mode_coil: assert property (@(posedge clock) disable iff (!reset_n)
		(load_now && target_of(shreg) == stp_pkg::TGT_COIL && step_interface_off)
		|=> coil_a_magnitude == $past(shreg[`STP_A_MAG])
			&& coil_b_polarity == $past(shreg[`STP_B_POL])
			&& microstep_resolution == `STP_ZERO_RES)
		else $error("coil currents not decoded in direct mode");

	a_coil_only: assert property (@(posedge clock) disable iff (!reset_n)
		(load_now && !shreg[`STP_ADDR_MSB])
		|=> $stable(chopper_config) && $stable(driver_config)
			&& $stable(load_detect_config) && $stable(load_adaptive_current_config))
		else $error("coil command wrote another register");

	a_status_park: assert property (@(posedge clock) disable iff (!reset_n)
		(ce && sel_fall) |=> shreg == $past(resp_word) && sdo == $past(resp_word[19]))
		else $error("status word not parked at select fall");

	a_sdo_enable: assert property (@(posedge clock) disable iff (!reset_n)
		ce |=> sdo_en == $past(active))
		else $error("output enable does not follow select");

	a_shift_hold: assert property (@(posedge clock) disable iff (!reset_n)
		(ce && !sel_fall && !(active && sck_rise)) |=> $stable(shreg))
		else $error("shift register moved without a rising clock");

	a_other_hold: assert property (@(posedge clock) disable iff (!reset_n)
		(!load_now) |=> $stable(chopper_config) && $stable(coil_drive_word)
			&& $stable(load_adaptive_current_config))
		else $error("register written without select rise");

	// Clock enable low must hold every state bit, synchronisers included
	a_enable_freeze: assert property (@(posedge clock) disable iff (!reset_n)
		(!ce) |=> $stable(shreg) && $stable(sdo) && $stable(sdo_en)
			&& $stable(driver_disable) && $stable(sck_lvl))
		else $error("state moved while clock enable was low");
endmodule

// ---- sim/stp_host_model.sv ----
// Host-side serial master model driving the configuration port
`timescale 1ns/1ps
module stp_host_model (
	input  wire logic clock,
	input  wire logic sdo,
	output logic      sck,
	output logic      sdi,
	output logic      select_low
);
	// Half of the 80 ns link period, counted in 5 ns system clocks
	localparam int HALF = 8;

	initial
	begin
		sck        = 1'b1;
		sdi        = 1'b0;
		select_low = 1'b1;
	end

	task automatic wait_clk(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Any bit count up to 40: 20 bits per chained device, plus any padding
	task automatic xfer(input int n, input logic [39:0] d, output logic [39:0] q);
		q = 40'h0;
		wait_clk(1);
		select_low = 1'b0;
		wait_clk(12);
		for (int i = n - 1; i >= 0; i--)
		begin
			sck = 1'b0; // Data changes on the falling edge
			sdi = d[i]; // MSB first; fixed bits are the caller's values
			wait_clk(HALF); // 80 ns period, well under half the system rate
			sck = 1'b1;
			wait_clk(HALF);
			q = {q[38:0], sdo};
		end
		wait_clk(2); // Keep sck high around the select edge
		select_low = 1'b1;
		sdi        = ~sdi; // Released line must not keep its last value
	endtask

	// Select pulse too short to be a frame
	task automatic pulse_select(input int n);
		select_low = 1'b0;
		wait_clk(n);
		select_low = 1'b1;
	endtask
endmodule

// ---- sim/test_stp_spi_config_writer.sv ----
// Self-checking bench for the serial configuration port
`timescale 1ns/1ps
module test_stp_spi_config_writer;
	logic        clock;
	logic        reset_n;
	logic        ce;
	logic        sck;
	logic        sdi;
	logic        select_low;
	logic        driver_disable_in;
	logic [9:0]  microstep_pos;
	logic [9:0]  load_value;
	logic [4:0]  current_scale_actual;
	logic [8:0]  protect_flags;
	logic [7:0]  diag_flags;
	logic        sdo;
	logic        sdo_en;
	logic        driver_disable;
	logic [19:0] coil_drive_word;
	logic [19:0] chopper_config;
	logic [19:0] load_adaptive_current_config;
	logic [19:0] load_detect_config;
	logic [19:0] driver_config;
	logic        step_interface_off;
	logic [1:0]  readback_select;
	logic        sense_voltage_range;
	logic        coil_a_polarity;
	logic [7:0]  coil_a_magnitude;
	logic        coil_b_polarity;
	logic [7:0]  coil_b_magnitude;
	logic        step_interpolation_en;
	logic        double_edge_step;
	logic [3:0]  microstep_resolution;
	logic [19:0] exp_reg [5];
	logic        coil_mode;
	int          seed;
	int          n_mismatch;
	int          n_compared;

	// Clock enable is driven too, so the freeze path is exercised
	stp_spi_config_writer u_dut (.clock, .reset_n, .ce, .sck, .sdi, .select_low,
		.driver_disable_in, .microstep_pos, .load_value, .current_scale_actual,
		.protect_flags, .diag_flags, .sdo, .sdo_en, .driver_disable, .coil_drive_word,
		.chopper_config, .load_adaptive_current_config, .load_detect_config,
		.driver_config, .step_interface_off, .readback_select, .sense_voltage_range,
		.coil_a_polarity, .coil_a_magnitude, .coil_b_polarity, .coil_b_magnitude,
		.step_interpolation_en, .double_edge_step, .microstep_resolution);

	stp_host_model u_host (.clock, .sdo, .sck, .sdi, .select_low);

	always #2.5 clock = ~clock;

	////////////////////////////////////////////////////////////////////////////////
	task automatic check(input logic [127:0] seen, input logic [127:0] want);
		n_compared++;
		if (seen !== want)
		begin
			n_mismatch++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, want);
		end
	endtask

	task automatic results();
		$display("compared %0d mismatched %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// Field bits kept per register, written out from the command formats
	function automatic logic [19:0] mask_of(input int s, input logic spi_mode);
		case (s)
			0:       return spi_mode ? 20'h3ffff : 20'h0030f;
			1:       return 20'h1ffff;
			2:       return 20'h0ef6f;
			3:       return 20'h17f1f;
			default: return 20'h1f7ff;
		endcase
	endfunction

	function automatic logic [19:0] status_of(input logic [1:0] rs);
		case (rs)
			2'h0:    return {microstep_pos, 2'h0, diag_flags};
			2'h1:    return {load_value, 2'h0, diag_flags};
			2'h2:    return {load_value[9:5], current_scale_actual, 2'h0, diag_flags};
			default: return {protect_flags[8], driver_disable_in, protect_flags[7:0], 2'h3,
				diag_flags};
		endcase
	endfunction

	task automatic check_outputs();
		logic [19:0] e;
		e = exp_reg[0];
		check({coil_drive_word, chopper_config, load_adaptive_current_config,
			load_detect_config, driver_config}, {exp_reg[0], exp_reg[1], exp_reg[2],
			exp_reg[3], exp_reg[4]});
		check({step_interface_off, readback_select, sense_voltage_range},
			{exp_reg[4][7], exp_reg[4][5:4], exp_reg[4][6]});
		check({coil_a_polarity, coil_a_magnitude, coil_b_polarity, coil_b_magnitude,
			step_interpolation_en, double_edge_step, microstep_resolution},
			coil_mode ? {e[17:0], 6'h0} : {18'h0, e[9:8], e[3:0]});
		check(sdo_en, 1'b0);
	endtask

	// Sends n bits; only the last 20 form the command, earlier bits come back on sdo
	task automatic write(input int n, input logic [39:0] d);
		logic [39:0] q;
		logic [19:0] c;
		int          s;
		microstep_pos        = 10'($random(seed));
		load_value           = 10'($random(seed));
		current_scale_actual = 5'($random(seed));
		protect_flags        = 9'($random(seed));
		diag_flags           = 8'($random(seed));
		driver_disable_in    = 1'($random(seed));
		c = d[19:0];
		s = c[19] ? 1 + int'(c[18:17]) : 0;
		c = c & (mask_of(s, exp_reg[4][7]) | (s == 0 ? 20'hc0000 : 20'he0000));
		d[19:0] = c;
		u_host.xfer(n, d, q);
		check(q, ({20'h0, status_of(exp_reg[4][5:4])} << (n - 20))
			| (d >> 20));
		u_host.wait_clk(14);
		exp_reg[s] = c & mask_of(s, exp_reg[4][7]);
		if (s == 0)
			coil_mode = exp_reg[4][7];
		check_outputs();
	endtask

	initial
	begin
		repeat (100000) @(posedge clock);
		n_mismatch++;
		results();
	end

	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		logic [39:0] d;
		int          n;
		seed                 = 32'h243b;
		clock                = 1'b0;
		reset_n              = 1'b0;
		driver_disable_in    = 1'b1;
		ce                   = 1'b1;
		microstep_pos        = 10'($random(seed));
		load_value           = 10'($random(seed));
		current_scale_actual = 5'($random(seed));
		protect_flags        = 9'($random(seed));
		diag_flags           = 8'($random(seed));
		coil_mode            = 1'b0;
		for (int i = 0; i < 5; i++)
			exp_reg[i] = 20'h0;
		repeat (3) @(posedge clock);
		#1 reset_n = 1'b1;
		check(driver_disable, 1'b1);
		check_outputs();
		u_host.wait_clk(10);
		$display("test reset done");

		// Every register in both coil modes, every readback format
		for (int m = 0; m < 4; m++)
		begin
			for (int a = 7; a >= 3; a--)
			begin
				d = 40'($unsigned($random(seed))) & 40'hfffff;
				d[19:17] = a > 3 ? 3'(a) : {2'h0, d[17]};
				if (a == 7)
				begin
					d[7]   = m[0];
					d[5:4] = 2'(m);
				end
				write(20, d);
			end
		end
		$display("test registers done");

		// Random data at three cycled lengths: plain, dummy-padded and two-device chains
		for (int k = 0; k < 30; k++)
		begin
			n = k % 3 == 0 ? 20 : (k % 3 == 1 ? 24 : 40);
			d = 40'({$random(seed), $random(seed)});
			write(n, d & ((40'h1 << n) - 40'h1));
		end
		$display("test chaining done");

		// Clock enable low freezes the filters; the change lands once it returns
		driver_disable_in = 1'b1;
		u_host.wait_clk(14);
		ce = 1'b0;
		driver_disable_in = 1'b0;
		u_host.wait_clk(14);
		check(driver_disable, 1'b1);
		ce = 1'b1;
		u_host.wait_clk(14);
		check(driver_disable, 1'b0);
		driver_disable_in = 1'b1;
		u_host.wait_clk(14);
		check(driver_disable, 1'b1);
		$display("test freeze done");

		// Short pulses ignored, long ones taken
		driver_disable_in = 1'b0;
		u_host.wait_clk(2);
		driver_disable_in = 1'b1;
		u_host.pulse_select(2);
		for (int i = 0; i < 14; i++)
		begin
			check({sdo_en, driver_disable}, 2'h1);
			u_host.wait_clk(1);
		end
		check_outputs();
		driver_disable_in = 1'b0;
		u_host.wait_clk(14);
		check(driver_disable, 1'b0);
		driver_disable_in = 1'b1;
		u_host.wait_clk(14);
		check(driver_disable, 1'b1);
		$display("test filter done");
		results();
	end
endmodule
